// ==== design/qdc_pkg.sv ====
// package: frame layout, register map and shared types of the quad converter update block
package qdc_pkg;

  // ****************************************
  // frame layout
  // ****************************************
  localparam int FRAME_BITS  = 24;
  localparam int CNT_W       = 5;
  localparam int POS_ADDR_HI = 23;
  localparam int POS_ADDR_LO = 22;
  localparam int POS_LD_HI   = 21;
  localparam int POS_LD_LO   = 20;
  localparam int POS_SEL_HI  = 18;
  localparam int POS_SEL_LO  = 17;
  localparam int POS_PD0     = 16;
  localparam int POS_PD2     = 14;
  localparam int POS_REF_HI  = 13;
  localparam int POS_REF_LO  = 12;
  localparam int CODE_W      = 16;
  localparam int NUM_CH      = 4;
  localparam int PD_W        = 3;

  localparam logic [CNT_W-1:0] LAST_BIT = 5'h17;
  localparam logic [1:0]       LD_WRITE = 2'h0;
  localparam logic [1:0]       LD_ONE   = 2'h1;
  localparam logic [1:0]       LD_ALL   = 2'h2;
  localparam logic [1:0]       LD_BCAST = 2'h3;
  localparam logic [PD_W-1:0]  PD_REF   = 3'h4;
  localparam logic [PD_W-1:0]  PD_1K    = 3'h5;
  localparam logic [PD_W-1:0]  PD_100K  = 3'h6;
  localparam logic [1:0]       REF_ON   = 2'h1;
  localparam logic [1:0]       REF_OFF  = 2'h2;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_BUF    = 8'h10;
  localparam logic [7:0] OFS_DAC    = 8'h20;
  localparam logic [7:0] OFS_BLK_M  = 8'hf0;
  localparam logic       CTRL_RST   = 1'b1;
  localparam int         ST_FRAMES  = 8;
  localparam int         ST_ABORTS  = 16;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic [PD_W-1:0]   pd;
    logic [CODE_W-1:0] code;
  } qdc_chan_t;

  typedef struct packed {
    logic sclk;
    logic sync_n;
    logic din;
  } qdc_link_t;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_1K,
    MODE_100K,
    MODE_HIZ
  } qdc_mode_t;

endpackage : qdc_pkg

// ==== design/qdc_serial_update.sv ====
// serial frame decode, channel buffers, converter registers and register slave
//
// The AHB-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps

// Functional notes
// - after reset all converter registers are zero and outputs sit at zero-scale
// - reference is on after reset until a reference-change frame switches it
// - frame-driven updates happen at the 24th falling link clock edge
// - rising load strobe copies every buffer into its converter register together
// - a buffer not rewritten leaves its register unchanged after the strobe
// - enable pin high makes the block ignore all serial traffic
// - power-down bits sit at frame bits 16, 15 and 14
// - bit0 clear is normal; 101, 110, 111 select 1k, 100k, high-impedance
// - power-down settings travel through buffers and loads like data
// - a power-down setting never alters the stored converter code
// - frame bits 23 and 22 must equal the two strapped address pins unless both load bits are set (broadcast)
// - both load bits clear writes only the selected buffer, outputs untouched
// - load bits 10 write the buffer, then load all four registers
// - load bits 01 write the buffer and load only that channel
// - select bits 18 and 17 pick channel A to D for 00 to 11
// - frame sync rising before the 24th edge discards the whole frame
module qdc_serial_update (
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic                         hreadyout,
  output logic      [31:0]             hrdata,
  output logic                         hresp,
  input  wire qdc_pkg::qdc_link_t      link,
  input  wire logic                    port_en_n,
  input  wire logic                    async_load_strobe,
  input  wire logic                    dev_addr_pin_hi,
  input  wire logic                    dev_addr_pin_lo,
  output qdc_pkg::qdc_chan_t [3:0]     dac_reg,
  output qdc_pkg::qdc_mode_t [3:0]     out_mode,
  output logic                         ref_on
);
  import qdc_pkg::*;

  // ****************************************
  // pin synchronisation and edges
  // ****************************************
  localparam int           NPIN     = 7;
  localparam logic [NPIN-1:0] PIN_RST = 7'h60;

  logic [NPIN-1:0] pins_raw;
  logic [NPIN-1:0] pins_s;
  logic            sclk_s;
  logic            sync_n_s;
  logic            din_s;
  logic            en_off_s;
  logic            async_load_strobe_s;
  logic [1:0]      addr_pins_s;
  logic            sclk_q;
  logic            sync_n_q;
  logic            async_load_strobe_q;
  logic            sclk_fall;
  logic            sync_fall;
  logic            sync_rise;
  logic            async_load_strobe_rise;

  assign pins_raw = {link.sclk, link.sync_n, link.din, port_en_n, async_load_strobe,
                     dev_addr_pin_hi, dev_addr_pin_lo};

  qdc_sync2 #(.W(NPIN), .RST(PIN_RST)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d_in    (pins_raw),
    .d_out   (pins_s)
  );

  assign sclk_s      = pins_s[6];
  assign sync_n_s    = pins_s[5];
  assign din_s       = pins_s[4];
  assign en_off_s    = pins_s[3];
  assign async_load_strobe_s      = pins_s[2];
  assign addr_pins_s = pins_s[1:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sclk_q   <= 1'b1;
      sync_n_q <= 1'b1;
      async_load_strobe_q   <= 1'b0;
    end else begin
      sclk_q   <= sclk_s;
      sync_n_q <= sync_n_s;
      async_load_strobe_q   <= async_load_strobe_s;
    end
  end

  assign sclk_fall = sclk_q & ~sclk_s;
  assign sync_fall = sync_n_q & ~sync_n_s;
  assign sync_rise = ~sync_n_q & sync_n_s;
  assign async_load_strobe_rise = ~async_load_strobe_q & async_load_strobe_s;

  // ****************************************
  // frame receiver
  // ****************************************
  typedef enum logic [1:0] {
    FS_IDLE,
    FS_SHIFT,
    FS_DONE
  } qdc_fstate_t;

  qdc_fstate_t            state_q;
  qdc_fstate_t            state_d;
  logic [FRAME_BITS-2:0]  shift_q;
  logic [FRAME_BITS-2:0]  shift_d;
  logic [CNT_W-1:0]       cnt_q;
  logic [CNT_W-1:0]       cnt_d;
  logic                   ctrl_en_q;
  logic                   frame_start;
  logic                   abort;
  logic                   exec;

  assign frame_start = (state_q == FS_IDLE) & sync_fall & ~en_off_s & ctrl_en_q;
  assign abort       = (state_q == FS_SHIFT) & (sync_rise | en_off_s);
  assign exec        = (state_q == FS_SHIFT) & ~abort & sclk_fall & (cnt_q == LAST_BIT);

  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    cnt_d   = cnt_q;
    case (state_q)
      FS_IDLE: begin
        if (frame_start) begin
          state_d = FS_SHIFT;
          shift_d = '0;
          cnt_d   = '0;
        end
      end
      FS_SHIFT: begin
        if (abort) begin
          state_d = FS_IDLE;
          shift_d = '0;
        end else if (exec) begin
          state_d = FS_DONE;
        end else if (sclk_fall) begin
          shift_d = {shift_q[FRAME_BITS-3:0], din_s};
          cnt_d   = cnt_q + 5'h01;
        end
      end
      FS_DONE: begin
        if (sync_rise | en_off_s) begin
          state_d = FS_IDLE;
        end
      end
      default: state_d = FS_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= FS_IDLE;
      shift_q <= '0;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      shift_q <= shift_d;
      cnt_q   <= cnt_d;
    end
  end

  // ****************************************
  // frame decode
  // ****************************************
  logic [FRAME_BITS-1:0] frm;
  logic [1:0]            frm_addr;
  logic [1:0]            frm_ld;
  logic [1:0]            frm_sel;
  logic [PD_W-1:0]       frm_pd;
  logic [1:0]            frm_ref;
  logic [CODE_W-1:0]     frm_code;
  logic                  bcast;
  logic                  exec_ok;
  logic                  ref_cmd;
  logic                  wr_buf;
  logic                  load_all;
  logic                  load_one;

  assign frm      = {shift_q, din_s};
  assign frm_addr = frm[POS_ADDR_HI:POS_ADDR_LO];
  assign frm_ld   = frm[POS_LD_HI:POS_LD_LO];
  assign frm_sel  = frm[POS_SEL_HI:POS_SEL_LO];
  assign frm_pd   = frm[POS_PD0:POS_PD2];
  assign frm_ref  = frm[POS_REF_HI:POS_REF_LO];
  assign frm_code = frm[CODE_W-1:0];
  assign bcast    = (frm_ld == LD_BCAST);
  assign exec_ok  = exec & (bcast | (frm_addr == addr_pins_s));
  assign ref_cmd  = exec_ok & (frm_pd == PD_REF);
  assign wr_buf   = exec_ok & ~ref_cmd & (~bcast | frm_sel[1]);
  assign load_all = exec_ok & ~ref_cmd & ((frm_ld == LD_ALL) | bcast);
  assign load_one = exec_ok & ~ref_cmd & (frm_ld == LD_ONE);

  function automatic qdc_mode_t pd_decode(input logic [PD_W-1:0] pd);
    qdc_mode_t m;
    m = MODE_HIZ;
    if (!pd[PD_W-1]) begin
      m = MODE_NORMAL;
    end else if (pd == PD_1K) begin
      m = MODE_1K;
    end else if (pd == PD_100K) begin
      m = MODE_100K;
    end
    return m;
  endfunction : pd_decode

  // ****************************************
  // buffers and converter registers
  // ****************************************
  qdc_chan_t [NUM_CH-1:0] buf_q;
  qdc_chan_t [NUM_CH-1:0] buf_d;
  qdc_chan_t [NUM_CH-1:0] dac_d;
  logic      [NUM_CH-1:0] load_ch;
  logic      [NUM_CH*CODE_W-1:0] dac_codes;
  logic      ref_on_d;

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    logic hit;
    assign hit = bcast | (frm_sel == 2'(i));
    always_comb begin
      buf_d[i] = buf_q[i];
      if (wr_buf & hit) begin
        buf_d[i].pd = frm_pd;
        if (!frm_pd[PD_W-1]) begin
          buf_d[i].code = frm_code;
        end
      end
    end
    assign load_ch[i] = async_load_strobe_rise | load_all | (load_one & hit);
    assign dac_d[i]   = load_ch[i] ? buf_d[i] : dac_reg[i];
    assign dac_codes[i*CODE_W +: CODE_W] = dac_reg[i].code;

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        buf_q[i]    <= '0;
        dac_reg[i]  <= '0;
        out_mode[i] <= MODE_NORMAL;
      end else begin
        buf_q[i]    <= buf_d[i];
        dac_reg[i]  <= dac_d[i];
        out_mode[i] <= pd_decode(dac_d[i].pd);
      end
    end
  end

  assign ref_on_d = (ref_cmd & (frm_ref == REF_ON))  ? 1'b1 :
                    (ref_cmd & (frm_ref == REF_OFF)) ? 1'b0 : ref_on;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_on <= 1'b1;
    end else begin
      ref_on <= ref_on_d;
    end
  end

  // ****************************************
  // register slave
  // ****************************************
  logic [7:0]  frames_q;
  logic [7:0]  aborts_q;
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic        a_ok;
  logic [7:0]  a_ofs;
  logic [31:0] status_w;
  logic [31:0] rd_mux;
  logic        ctrl_wr;

  assign a_ok     = hsel & htrans[1] & hready;
  assign a_ofs    = haddr[7:0];
  assign status_w = {8'h00, aborts_q, frames_q, 5'h00, ~en_off_s, (state_q != FS_IDLE), ref_on};
  assign rd_mux   = (a_ofs == OFS_CTRL)   ? {31'h0, ctrl_en_q} :
                    (a_ofs == OFS_STATUS) ? status_w :
                    ((a_ofs & OFS_BLK_M) == OFS_BUF) && (a_ofs[1:0] == 2'h0) ?
                      {13'h0, buf_q[a_ofs[3:2]]} :
                    ((a_ofs & OFS_BLK_M) == OFS_DAC) && (a_ofs[1:0] == 2'h0) ?
                      {13'h0, dac_reg[a_ofs[3:2]]} : 32'h0;
  assign ctrl_wr  = wr_pend_q & (wr_addr_q == OFS_CTRL);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      hrdata    <= '0;
    end else begin
      wr_pend_q <= a_ok & hwrite;
      wr_addr_q <= a_ofs;
      hrdata    <= (a_ok & ~hwrite) ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_en_q <= CTRL_RST;
      frames_q  <= '0;
      aborts_q  <= '0;
    end else begin
      ctrl_en_q <= ctrl_wr ? hwdata[0] : ctrl_en_q;
      frames_q  <= frames_q + 8'(exec_ok);
      aborts_q  <= aborts_q + 8'(abort);
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic [CNT_W-1:0] chk_falls_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chk_falls_q <= '0;
    end else begin
      chk_falls_q <= sync_fall ? '0 : chk_falls_q + CNT_W'(sclk_fall & ~sync_n_s & ~&chk_falls_q);
    end
  end

  sequence s_last_edge;
    (state_q == FS_SHIFT) && (cnt_q == LAST_BIT) && sclk_fall;
  endsequence

  chk_exec_at_24th: assert property (exec |-> s_last_edge ##0 (chk_falls_q == LAST_BIT))
    else $error("frame executed away from the 24th falling edge");
  chk_abort_clean: assert property (abort && !async_load_strobe_rise |=> $stable(buf_q) && $stable(dac_reg) && $stable(ref_on)
                                    && (state_q == FS_IDLE))
    else $error("aborted frame changed state");
  chk_enable_ignore: assert property (en_off_s |=> (state_q == FS_IDLE) && $stable(buf_q))
    else $error("traffic accepted while enable pin high");
  chk_async_load_strobe_copy_all: assert property (async_load_strobe_rise && !exec |=> dac_reg == $past(buf_q))
    else $error("load strobe did not copy all buffers");
  chk_dac_cause: assert property (!$stable(dac_reg) |-> $past(async_load_strobe_rise || load_all || load_one))
    else $error("converter register changed without a load");
  chk_ref_change: assert property (!$stable(ref_on) |-> $past(ref_cmd))
    else $error("reference changed without a command");
  chk_pd_keeps_code: assert property (exec_ok && frm_pd[PD_W-1] && !load_all && !async_load_strobe_rise
                                      |=> $stable(dac_codes))
    else $error("power-down altered a stored code");
  chk_addr_reject: assert property (exec && !bcast && (frm_addr != addr_pins_s) && !async_load_strobe_rise
                                    |=> $stable(buf_q) && $stable(dac_reg))
    else $error("frame for another address was taken");
  chk_single_load: assert property (load_one && !async_load_strobe_rise && !frm_pd[PD_W-1]
                                    |=> dac_reg[$past(frm_sel)].code == $past(frm_code) ##1
                                        $stable(dac_reg))
    else $error("single-channel load wrong");
  chk_mode_hiz: assert property ((dac_reg[0].pd == 3'h7) |-> (out_mode[0] == MODE_HIZ))
    else $error("high-impedance code decoded wrongly");

endmodule : qdc_serial_update

// ==== design/qdc_sync2.sv ====
// two-flop synchroniser for a group of pin levels
`timescale 1ns/10ps
module qdc_sync2 #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] d_out
);

  logic [W-1:0] meta_q;

  if (W < 1) begin : g_bad_width
    $error("qdc_sync2: width must be at least one");
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= RST;
      d_out  <= RST;
    end else begin
      meta_q <= d_in;
      d_out  <= meta_q;
    end
  end

endmodule : qdc_sync2

// ==== verification/qdc_host_model.sv ====
// partner model: host serial controller driving frames onto the three-wire link
`timescale 1ns/10ps
module qdc_host_model (
  output qdc_pkg::qdc_link_t link
);
  import qdc_pkg::*;
  // ****************************************
  // idle levels, clock stands still high
  // ****************************************
  initial begin
    link.sclk   = 1'b1;
    link.sync_n = 1'b1;
    link.din    = 1'b0;
  end
  // ****************************************
  // frame transmit
  // ****************************************
  // a cut below the frame length raises sync early and aborts the frame
  task automatic send(input logic [23:0] f, input int cut);
    #7;
    link.sync_n = 1'b0;
    for (int i = 0; i < cut; i++) begin
      link.din = f[FRAME_BITS-1-i];
      #160;
      link.sclk = 1'b0;
      #160;
      link.sclk = 1'b1;
    end
    #160;
    link.din    = ~link.din;
    link.sync_n = 1'b1;
  endtask : send
endmodule : qdc_host_model

// ==== verification/tb.sv ====
// testbench: host frames, load strobe and register bus against the update block
`timescale 1ns/10ps
module tb;
  import qdc_pkg::*;
  // ****************************************
  // signals and instances
  // ****************************************
  logic               hclk, hresetn, hsel, hwrite, hreadyout, hresp, port_en_n, async_load_strobe, ref_on;
  logic [31:0]        haddr, hwdata, hrdata, rd;
  logic [1:0]         htrans, pins;
  logic [2:0]         hsize;
  qdc_link_t          link;
  qdc_chan_t [3:0]    dac_reg;
  qdc_mode_t [3:0]    out_mode;
  int                 fails, n_tests;

  qdc_host_model u_host (.link(link));
  qdc_serial_update u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .link(link), .port_en_n(port_en_n), .async_load_strobe(async_load_strobe),
    .dev_addr_pin_hi(pins[1]), .dev_addr_pin_lo(pins[0]), .dac_reg(dac_reg), .out_mode(out_mode),
    .ref_on(ref_on));

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
    @(negedge hclk);
  endtask : cyc

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    for (int p = 0; p < 2; p++) begin
      n = 0;
      do begin
        @(posedge hclk);
        n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin
        fails++;
        end_of_test();
      end
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
    end
    rd = hrdata;
  endtask : ahb

  task automatic frm(input logic [1:0] a, input logic [1:0] ld, input logic [1:0] sel, input logic b16,
                     input logic [15:0] d, input int cut);
    u_host.send({a, ld, 1'b0, sel, b16, d}, cut);
    cyc(6);
  endtask : frm

  task automatic dchk(input int i, input logic [15:0] e);
    chk("dac code", {16'h0, dac_reg[i].code}, {16'h0, e});
  endtask : dchk
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    for (int i = 0; i < 4; i++) begin
      dchk(i, 16'h0);
      chk("out mode", {30'h0, out_mode[i]}, 32'h0);
    end
    chk("ref on", {31'h0, ref_on}, 32'h1);
    ahb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl", rd, 32'h1);
    chk("hresp", {31'h0, hresp}, 32'h0);
    ahb(1'b0, 8'h08, 32'h0);
    chk("unmapped", rd, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_loads();
    logic [15:0] e [4] = '{16'h1000, 16'h1001, 16'hc0de, 16'hd00d};
    for (int i = 0; i < 4; i++) begin
      frm(2'h1, LD_WRITE, 2'(i), 1'b0, 16'h1000 + 16'(i), 24);
      ahb(1'b0, OFS_BUF + 8'(4 * i), 32'h0);
      chk("buffer", {16'h0, rd[15:0]}, 32'h1000 + i);
      dchk(i, 16'h0);
    end
    frm(2'h1, LD_ONE, 2'h2, 1'b0, 16'hc0de, 24);
    dchk(2, 16'hc0de);
    dchk(1, 16'h0);
    frm(2'h1, LD_ALL, 2'h3, 1'b0, 16'hd00d, 24);
    for (int i = 0; i < 4; i++) begin
      dchk(i, e[i]);
    end
    $display("test loads done");
  endtask : t_loads

  task automatic t_strobe();
    frm(2'h1, LD_WRITE, 2'h0, 1'b0, 16'haaaa, 24);
    dchk(0, 16'h1000);
    @(posedge hclk);
    async_load_strobe <= 1'b1;
    cyc(6);
    dchk(0, 16'haaaa);
    dchk(1, 16'h1001);
    ahb(1'b0, OFS_DAC, 32'h0);
    chk("dac read", {16'h0, rd[15:0]}, 32'haaaa);
    @(posedge hclk);
    async_load_strobe <= 1'b0;
    cyc(2);
    $display("test strobe done");
  endtask : t_strobe

  task automatic t_pwrdn();
    logic [2:0] pat [3] = '{3'h5, 3'h6, 3'h7};
    for (int k = 0; k < 3; k++) begin
      frm(2'h1, LD_ONE, 2'h1, 1'b1, {pat[k][1:0], 14'h0}, 24);
      chk("out mode", {30'h0, out_mode[1]}, 32'(k + 1));
      chk("pd field", {29'h0, dac_reg[1].pd}, {29'h0, pat[k]});
      dchk(1, 16'h1001);
    end
    frm(2'h1, LD_ONE, 2'h1, 1'b0, 16'h1001, 24);
    chk("out mode", {30'h0, out_mode[1]}, 32'h0);
    frm(2'h1, LD_ALL, 2'h3, 1'b1, 16'h8000, 24);
    chk("out mode", {30'h0, out_mode[3]}, 32'h2);
    chk("out mode", {30'h0, out_mode[0]}, 32'h0);
    dchk(0, 16'haaaa);
    $display("test power-down done");
  endtask : t_pwrdn

  task automatic t_refuse();
    frm(2'h1, LD_ONE, 2'h0, 1'b0, 16'h5555, 23);
    dchk(0, 16'haaaa);
    frm(2'h2, LD_ONE, 2'h0, 1'b0, 16'h5555, 24);
    dchk(0, 16'haaaa);
    @(posedge hclk);
    port_en_n <= 1'b1;
    cyc(3);
    frm(2'h1, LD_ONE, 2'h0, 1'b0, 16'h5555, 24);
    dchk(0, 16'haaaa);
    @(posedge hclk);
    port_en_n <= 1'b0;
    cyc(3);
    ahb(1'b1, OFS_CTRL, 32'h0);
    frm(2'h1, LD_ONE, 2'h0, 1'b0, 16'h5555, 24);
    dchk(0, 16'haaaa);
    ahb(1'b1, OFS_CTRL, 32'h1);
    frm(2'h1, LD_ONE, 2'h0, 1'b0, 16'h5555, 24);
    dchk(0, 16'h5555);
    $display("test refuse done");
  endtask : t_refuse

  task automatic t_ref();
    frm(2'h1, LD_WRITE, 2'h0, 1'b1, 16'h2000, 24);
    chk("ref on", {31'h0, ref_on}, 32'h0);
    ahb(1'b0, OFS_STATUS, 32'h0);
    chk("status ref", {31'h0, rd[0]}, 32'h0);
    chk("status", rd, 32'h00010e04);
    dchk(0, 16'h5555);
    frm(2'h1, LD_WRITE, 2'h0, 1'b1, 16'h1000, 24);
    chk("ref on", {31'h0, ref_on}, 32'h1);
    $display("test reference done");
  endtask : t_ref

  task automatic t_bcast();
    frm(2'h2, LD_BCAST, 2'h2, 1'b0, 16'h7777, 24);
    for (int i = 0; i < 4; i++) begin
      dchk(i, 16'h7777);
      chk("out mode", {30'h0, out_mode[i]}, 32'h0);
    end
    $display("test broadcast done");
  endtask : t_bcast

  task automatic t_rerun();
    ahb(1'b1, OFS_CTRL, 32'h0);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    cyc(4);
    t_reset();
    $display("test second reset done");
  endtask : t_rerun
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    hresetn           = 1'b0;
    hsel              = 1'b0;
    haddr             = 32'h0;
    htrans            = 2'h0;
    hwrite            = 1'b0;
    hsize             = 3'h2;
    hwdata            = 32'h0;
    port_en_n         = 1'b0;
    async_load_strobe = 1'b0;
    pins              = 2'h1;
    fails             = 0;
    n_tests           = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    cyc(4);
    t_reset();
    t_loads();
    t_strobe();
    t_pwrdn();
    t_refuse();
    t_ref();
    t_bcast();
    t_rerun();
    end_of_test();
  end
endmodule : tb
